/* File: pkg/eewr_pkg.sv */
/*
  Constants, states and helpers of the serial EEPROM array access block.
  Assumes a 40 MHz core clock and a serial bus in positive-clock mode.
*/
package eewr_pkg;

  // ---------------------------------------------------------------
  // array geometry
  // ---------------------------------------------------------------
  localparam int ADDR_BITS_BIG   = 11;
  localparam int ADDR_BITS_SMALL = 10;
  localparam int PAGE_BITS       = 5;
  localparam int PAGE_BYTES      = 32;
  localparam int BYTE_BITS       = 8;
  localparam int FIELD_BITS      = 16;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // ---------------------------------------------------------------
  // instruction codes and frame bit counts
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_WRITE        = 8'h02;
  localparam logic [7:0] CMD_READ         = 8'h03;
  localparam logic [7:0] CMD_WRDI         = 8'h04;
  localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
  localparam logic [4:0] BYTE_LAST  = 5'h07;
  localparam logic [4:0] FIELD_LAST = 5'h0f;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int WRITE_CYCLE_NS     = 5000000;
  localparam int CORE_PERIOD_NS     = 25;
  localparam int WRITE_CYCLE_CYCLES = WRITE_CYCLE_NS / CORE_PERIOD_NS;

  // ---------------------------------------------------------------
  // state types
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    PH_CMD   = 5'h01,
    PH_ADDR  = 5'h02,
    PH_RDATA = 5'h04,
    PH_WDATA = 5'h08,
    PH_IGN   = 5'h10
  } eewr_phase_t;

  typedef enum logic [2:0] {
    CS_IDLE = 3'h1,
    CS_COPY = 3'h2,
    CS_WAIT = 3'h4
  } eewr_cstate_t;

  // protected region from the two block-protect bits and page top bits
  function automatic logic eewr_protected(input logic bp_hi, input logic bp_lo,
                                          input logic [1:0] top);
    case ({bp_hi, bp_lo})
      2'h0:    eewr_protected = 1'b0;
      2'h1:    eewr_protected = (top == 2'h3);
      2'h2:    eewr_protected = top[1];
      default: eewr_protected = 1'b1;
    endcase
  endfunction : eewr_protected

endpackage : eewr_pkg

/* File: logic/eewr_dpram.sv */
/*
  Two-clock simple dual-port memory with registered read data.
  Assumes writes and reads of one word are never in flight together.
*/
`timescale 1ns/1ps
module eewr_dpram #(
  parameter int         W    = 8,
  parameter int         D    = 32,
  parameter int         AW   = 5,
  parameter logic [7:0] INIT = 8'h00
) (
  // write port
  input  wire logic          wclk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  // read port
  input  wire logic          rclk,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);

  // power-on contents; no reset clears them
  logic [W-1:0] mem [D] = '{default: W'(INIT)};

  always_ff @(posedge wclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge rclk) begin
    rdata <= mem[raddr];
  end

endmodule : eewr_dpram

/* File: logic/eewr_top.sv */
/*
  Serial EEPROM array read/write instruction handling: link logic on the
  serial clock, self-timed write cycle and status bits on the core clock.
  Assumes select stays high for at least four core cycles between frames.
*/
`timescale 1ns/1ps
// Contract
// - Select low, read code and address load address and shift out that byte.
// - With select still low, address increments and next byte follows.
// - Sequential read wraps from highest address to zero.
// - Select high ends a read at any point, cleanly.
// - Any byte may start a read, no page alignment.
// - Read arriving during a write cycle is ignored.
// - Select rising at byte boundary starts write cycle; busy clears after.
// - One byte or several in one page written in one cycle.
// - Write data advance low five address bits; wrap within the page.
// - Write rejected unless write enable latch set before.
// - Write rejected while an earlier write cycle runs.
// - Select rising off a byte boundary discards the write.
// - Write into a block-protected page is rejected.
// - Delivery state: array all FFh, lock and protect bits zero.
// - Busy reads 1 during write cycle; latch cleared when it ends.
// - Only the low address bits are used; upper bits ignored.
// - Latch clear means array writes are not accepted.
module eewr_top #(
  parameter int AW          = eewr_pkg::ADDR_BITS_BIG,
  parameter int WCYC_CYCLES = eewr_pkg::WRITE_CYCLE_CYCLES
) (
  // core clock and reset
  input  wire logic CORE_CLK,
  input  wire logic RST_N,
  // serial link
  input  wire logic SCK,
  input  wire logic SEL_N,
  input  wire logic MOSI,
  output logic      MISO,
  output logic      MISO_OE,
  // status bit load
  input  wire logic STAT_LOAD,
  input  wire logic STAT_BP_HI,
  input  wire logic STAT_BP_LO,
  input  wire logic STAT_LOCK,
  // status
  output logic      WRITE_BUSY_FLAG,
  output logic      WRITE_ENABLE_LATCH,
  output logic      BLOCK_PROTECT_HI,
  output logic      BLOCK_PROTECT_LO,
  output logic      STATUS_LOCK_BIT
);

  localparam int PB   = eewr_pkg::PAGE_BITS;
  localparam int TMRW = $clog2(WCYC_CYCLES + 1);

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_m;
  logic rst_n;
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  // ---------------------------------------------------------------
  // link side: serial clock domain
  // ---------------------------------------------------------------
  eewr_pkg::eewr_phase_t phase;
  logic [4:0]                 cnt;
  logic [14:0]                sh;
  logic                       is_rd;
  logic [AW-1:0]              rd_addr;
  logic                       load;
  logic [7:0]                 out_sh;
  logic                       armed;
  logic                       ena_seen;
  logic                       wrdi_seen;
  logic [AW-PB-1:0]           page;
  logic [PB-1:0]              wptr;
  logic [(1<<PB)-1:0]         mask;
  logic                       busy_m;
  logic                       busy_s;
  logic [7:0]                 rdata;
  logic                       link_rst;
  logic [7:0]                 din;
  logic [eewr_pkg::FIELD_BITS-1:0] afull;
  logic [AW-1:0]              raddr;
  logic                       pb_we;

  assign link_rst = SEL_N | ~rst_n;
  assign din      = {sh[6:0], MOSI};
  assign afull    = {sh, MOSI};
  assign raddr    = (phase == eewr_pkg::PH_ADDR) ? afull[AW-1:0]
                                                 : AW'(rd_addr + 1'b1);
  assign pb_we    = (phase == eewr_pkg::PH_WDATA) && (cnt == eewr_pkg::BYTE_LAST);

  // busy flag into the link domain
  always_ff @(posedge SCK or negedge rst_n) begin
    if (!rst_n) begin
      busy_m <= 1'b0;
      busy_s <= 1'b0;
    end else begin
      busy_m <= WRITE_BUSY_FLAG;
      busy_s <= busy_m;
    end
  end

  // frame sequencer, cleared whenever select is high
  always_ff @(posedge SCK or posedge link_rst) begin
    if (link_rst) begin
      phase <= eewr_pkg::PH_CMD;
      cnt   <= 5'h00;
      is_rd <= 1'b0;
    end else begin
      cnt <= cnt + 5'h01;
      case (phase)
        eewr_pkg::PH_CMD: begin
          if (cnt == eewr_pkg::BYTE_LAST) begin
            cnt <= 5'h00;
            if (din == eewr_pkg::CMD_READ && !busy_s) begin
              phase <= eewr_pkg::PH_ADDR;
              is_rd <= 1'b1;
            end else if (din == eewr_pkg::CMD_WRITE) begin
              phase <= eewr_pkg::PH_ADDR;
              is_rd <= 1'b0;
            end else begin
              phase <= eewr_pkg::PH_IGN;
            end
          end
        end
        eewr_pkg::PH_ADDR: begin
          if (cnt == eewr_pkg::FIELD_LAST) begin
            cnt   <= 5'h00;
            phase <= is_rd ? eewr_pkg::PH_RDATA : eewr_pkg::PH_WDATA;
          end
        end
        eewr_pkg::PH_RDATA, eewr_pkg::PH_WDATA: begin
          if (cnt == eewr_pkg::BYTE_LAST) begin
            cnt <= 5'h00;
          end
        end
        eewr_pkg::PH_IGN: begin
          cnt <= 5'h00;
        end
        default: begin
          phase <= eewr_pkg::PH_IGN;
        end
      endcase
    end
  end

  // input shifter
  always_ff @(posedge SCK or negedge rst_n) begin
    if (!rst_n) begin
      sh <= 15'h0000;
    end else begin
      sh <= afull[14:0];
    end
  end

  // read address counter and load request
  always_ff @(posedge SCK or negedge rst_n) begin
    if (!rst_n) begin
      rd_addr <= '0;
      load    <= 1'b0;
    end else begin
      load <= 1'b0;
      if (phase == eewr_pkg::PH_ADDR && cnt == eewr_pkg::FIELD_LAST && is_rd) begin
        rd_addr <= afull[AW-1:0];
        load    <= 1'b1;
      end else if (phase == eewr_pkg::PH_RDATA && cnt == eewr_pkg::BYTE_LAST) begin
        rd_addr <= raddr;
        load    <= 1'b1;
      end
    end
  end

  // output shifter after falling edges
  always_ff @(negedge SCK or negedge rst_n) begin
    if (!rst_n) begin
      out_sh <= 8'hff;
    end else if (load) begin
      out_sh <= rdata;
    end else begin
      out_sh <= {out_sh[6:0], 1'b0};
    end
  end

  assign MISO    = out_sh[7];
  assign MISO_OE = (phase == eewr_pkg::PH_RDATA) && !SEL_N;

  // write bookkeeping; held after select rises for the core to sample
  always_ff @(posedge SCK or negedge rst_n) begin
    if (!rst_n) begin
      armed     <= 1'b0;
      ena_seen  <= 1'b0;
      wrdi_seen <= 1'b0;
      page      <= '0;
      wptr      <= '0;
      mask      <= '0;
    end else begin
      armed     <= pb_we;
      ena_seen  <= (phase == eewr_pkg::PH_CMD) && (cnt == eewr_pkg::BYTE_LAST)
                   && (din == eewr_pkg::WRITE_ENABLE_CMD);
      wrdi_seen <= (phase == eewr_pkg::PH_CMD) && (cnt == eewr_pkg::BYTE_LAST)
                   && (din == eewr_pkg::CMD_WRDI);
      if (phase == eewr_pkg::PH_ADDR && cnt == eewr_pkg::FIELD_LAST && !is_rd) begin
        page <= afull[AW-1:PB];
        wptr <= afull[PB-1:0];
        mask <= '0;
      end else if (pb_we) begin
        wptr       <= PB'(wptr + 1'b1);
        mask[wptr] <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // core side: select edge, status bits, write cycle
  // ---------------------------------------------------------------
  logic sel_m;
  logic sel_s;
  logic sel_d;
  logic sel_rise;
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sel_m <= 1'b1;
      sel_s <= 1'b1;
      sel_d <= 1'b1;
    end else begin
      sel_m <= SEL_N;
      sel_s <= sel_m;
      sel_d <= sel_s;
    end
  end
  assign sel_rise = sel_s & ~sel_d;

  eewr_pkg::eewr_cstate_t cst;
  logic [TMRW-1:0]        tmr;
  logic                   cyc_end;
  logic [PB:0]            cidx;
  logic [AW-PB-1:0]       cpage;
  logic [(1<<PB)-1:0]     cmask;
  logic [7:0]             pdata;
  logic                   commit;
  logic                   arr_we;
  logic [AW-1:0]          arr_waddr;
  logic [PB-1:0]          cprev;

  assign commit = sel_rise && armed && WRITE_ENABLE_LATCH
                  && (cst == eewr_pkg::CS_IDLE)
                  && !eewr_pkg::eewr_protected(BLOCK_PROTECT_HI, BLOCK_PROTECT_LO,
                                               page[AW-PB-1 -: 2]);
  assign cprev     = PB'(cidx - 1'b1);
  assign arr_we    = (cst == eewr_pkg::CS_COPY) && (cidx != '0) && cmask[cprev];
  assign arr_waddr = {cpage, cprev};
  assign cyc_end   = (cst == eewr_pkg::CS_WAIT) && (tmr == TMRW'(WCYC_CYCLES - 1));

  // write cycle sequencer
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cst   <= eewr_pkg::CS_IDLE;
      tmr   <= '0;
      cidx  <= '0;
      cpage <= '0;
      cmask <= '0;
    end else begin
      tmr <= TMRW'(tmr + 1'b1);
      case (cst)
        eewr_pkg::CS_IDLE: begin
          tmr <= '0;
          if (commit) begin
            cst   <= eewr_pkg::CS_COPY;
            cidx  <= '0;
            cpage <= page;
            cmask <= mask;
          end
        end
        eewr_pkg::CS_COPY: begin
          cidx <= cidx + 1'b1;
          if (cidx == (PB+1)'(eewr_pkg::PAGE_BYTES)) begin
            cst <= eewr_pkg::CS_WAIT;
          end
        end
        eewr_pkg::CS_WAIT: begin
          if (cyc_end) begin
            cst <= eewr_pkg::CS_IDLE;
          end
        end
        default: begin
          cst <= eewr_pkg::CS_IDLE;
        end
      endcase
    end
  end

  // busy from a flop, so the link-side synchroniser never sees a decode glitch
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      WRITE_BUSY_FLAG <= 1'b0;
    end else if (cst == eewr_pkg::CS_IDLE) begin
      WRITE_BUSY_FLAG <= commit;
    end else if (cyc_end) begin
      WRITE_BUSY_FLAG <= 1'b0;
    end
  end

  // write enable latch
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      WRITE_ENABLE_LATCH <= 1'b0;
    end else if (cyc_end) begin
      WRITE_ENABLE_LATCH <= 1'b0;
    end else if (sel_rise && cst == eewr_pkg::CS_IDLE && ena_seen) begin
      WRITE_ENABLE_LATCH <= 1'b1;
    end else if (sel_rise && cst == eewr_pkg::CS_IDLE && wrdi_seen) begin
      WRITE_ENABLE_LATCH <= 1'b0;
    end
  end

  // protect and lock bits, delivered clear
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      BLOCK_PROTECT_HI <= 1'b0;
      BLOCK_PROTECT_LO <= 1'b0;
      STATUS_LOCK_BIT  <= 1'b0;
    end else if (STAT_LOAD && cst == eewr_pkg::CS_IDLE) begin
      BLOCK_PROTECT_HI <= STAT_BP_HI;
      BLOCK_PROTECT_LO <= STAT_BP_LO;
      STATUS_LOCK_BIT  <= STAT_LOCK;
    end
  end

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  eewr_dpram #(.W(eewr_pkg::BYTE_BITS), .D(1 << AW), .AW(AW),
               .INIT(eewr_pkg::ERASED_BYTE)) u_array (
    .wclk  (CORE_CLK),
    .we    (arr_we),
    .waddr (arr_waddr),
    .wdata (pdata),
    .rclk  (SCK),
    .raddr (raddr),
    .rdata (rdata)
  );

  eewr_dpram #(.W(eewr_pkg::BYTE_BITS), .D(eewr_pkg::PAGE_BYTES), .AW(PB),
               .INIT(eewr_pkg::ERASED_BYTE)) u_page (
    .wclk  (SCK),
    .we    (pb_we),
    .waddr (wptr),
    .wdata (din),
    .rclk  (CORE_CLK),
    .raddr (cidx[PB-1:0]),
    .rdata (pdata)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_BUSY_ON_COMMIT: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    commit |=> WRITE_BUSY_FLAG [*8])
    else $error("write cycle did not start busy");
  AST_END_CLEARS: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    cyc_end |=> !WRITE_BUSY_FLAG && !WRITE_ENABLE_LATCH)
    else $error("busy or latch left set at cycle end");
  AST_BUSY_LEN: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    $fell(WRITE_BUSY_FLAG) |-> $past(tmr) == TMRW'(WCYC_CYCLES - 1))
    else $error("write cycle length wrong");
  AST_NEED_LATCH: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    $rose(WRITE_BUSY_FLAG) |-> $past(WRITE_ENABLE_LATCH) && $past(armed))
    else $error("write started without latch or boundary");
  AST_NO_RESTART: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    (cst == eewr_pkg::CS_WAIT && sel_rise) |=> cst != eewr_pkg::CS_COPY)
    else $error("write restarted during cycle");
  AST_PROTECT: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    arr_we |-> !eewr_pkg::eewr_protected(BLOCK_PROTECT_HI, BLOCK_PROTECT_LO,
                                        cpage[AW-PB-1 -: 2]))
    else $error("protected page written");
  AST_IN_PAGE: assert property (@(posedge SCK) disable iff (link_rst)
    pb_we |=> wptr == PB'($past(wptr) + 1'b1) && page == $past(page))
    else $error("page pointer left page");
  AST_READ_REJECT: assert property (@(posedge SCK) disable iff (link_rst)
    (phase == eewr_pkg::PH_CMD && cnt == eewr_pkg::BYTE_LAST
     && din == eewr_pkg::CMD_READ && busy_s) |=> phase == eewr_pkg::PH_IGN)
    else $error("read accepted while busy");
  AST_READ_WRAP: assert property (@(posedge SCK) disable iff (link_rst)
    (phase == eewr_pkg::PH_RDATA && cnt == eewr_pkg::BYTE_LAST && rd_addr == '1)
      |=> rd_addr == '0 && load)
    else $error("read address did not wrap");
  AST_QUIET: assert property (@(posedge SCK) disable iff (link_rst)
    phase != eewr_pkg::PH_RDATA |-> !MISO_OE)
    else $error("output driven outside read data");

endmodule : eewr_top

/* File: bench/eewr_spi_master.sv */
/*
  Serial bus master model that frames select, clock and data for the array block.
  Assumes one caller at a time; the clock stands still outside frames.
*/
`timescale 1ns/1ps
module eewr_spi_master (
  // serial link
  output logic      SCK,
  output logic      SEL_N,
  output logic      MOSI,
  input  wire logic MISO,
  input  wire logic MISO_OE
);
  logic last;
  logic oe_seen;

  initial begin
    SCK = 1'b0;
    SEL_N = 1'b1;
    MOSI = 1'b0;
    last = 1'b0;
    oe_seen = 1'b0;
  end

  // select low, phase offset from the core clock
  task automatic start();
    #3.1;
    oe_seen = 1'b0;
    SEL_N <= 1'b0;
    #62.5;
  endtask : start

  // n bits of d, msb first; undriven data reads as the inverse of the last bit
  task automatic xbyte(input logic [7:0] d, input int n, output logic [7:0] q);
    for (int i = 7; i > 7 - n; i--) begin
      MOSI <= d[i];
      #62.5;
      SCK <= 1'b1;
      q[i] = MISO_OE ? MISO : ~last;
      oe_seen = oe_seen | MISO_OE;
      last = q[i];
      #62.5;
      SCK <= 1'b0;
    end
  endtask : xbyte

  // select high before the next rising edge, then a long deselect gap
  task automatic stop();
    #20;
    SEL_N <= 1'b1;
    MOSI <= ~MOSI;
    #250;
  endtask : stop
endmodule : eewr_spi_master

/* File: bench/spi_eeprom_array_read_write_bench.sv */
/*
  Self-checking bench of the array block with a serial master model.
  Assumes a shortened write cycle of WCYC core cycles and the big variant.
*/
`timescale 1ns/1ps
module spi_eeprom_array_read_write_bench;
  localparam int WCYC = 800;
  logic       core_clk, rst_n, sck, sel_n, mosi, miso, miso_oe;
  logic       stat_load, stat_bp_hi, stat_bp_lo, stat_lock;
  logic       busy, latch, bp_hi, bp_lo, lock;
  logic [7:0] exp_mem [2048];
  logic [7:0] q;
  int         err_count, checked, busy_len;

  eewr_top #(.WCYC_CYCLES(WCYC)) i_eewr_top (
    .CORE_CLK(core_clk), .RST_N(rst_n), .SCK(sck), .SEL_N(sel_n), .MOSI(mosi),
    .MISO(miso), .MISO_OE(miso_oe), .STAT_LOAD(stat_load), .STAT_BP_HI(stat_bp_hi),
    .STAT_BP_LO(stat_bp_lo), .STAT_LOCK(stat_lock), .WRITE_BUSY_FLAG(busy),
    .WRITE_ENABLE_LATCH(latch), .BLOCK_PROTECT_HI(bp_hi), .BLOCK_PROTECT_LO(bp_lo),
    .STATUS_LOCK_BIT(lock));
  eewr_spi_master i_eewr_spi_master (
    .SCK(sck), .SEL_N(sel_n), .MOSI(mosi), .MISO(miso), .MISO_OE(miso_oe));

  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (busy === 1'b1) busy_len <= busy_len + 1;

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic sb(input logic [7:0] d);
    i_eewr_spi_master.xbyte(d, 8, q);
  endtask : sb

  task automatic frame(input logic [7:0] cmd, input logic [15:0] a, input int n,
                       input logic [7:0] base);
    i_eewr_spi_master.start();
    sb(cmd);
    sb(a[15:8]);
    sb(a[7:0]);
    for (int k = 0; k < n; k++) sb(base + 8'(k));
  endtask : frame

  task automatic rd(input logic [15:0] a, input int n);
    frame(eewr_pkg::CMD_READ, a, 0, 8'h00);
    chk(i_eewr_spi_master.oe_seen, 0);
    for (int k = 0; k < n; k++) begin
      sb(8'h00);
      chk(q, exp_mem[a[10:0] + 11'(k)]);
    end
    i_eewr_spi_master.xbyte(8'h00, 3, q);
    i_eewr_spi_master.stop();
    chk(miso_oe, 0);
  endtask : rd

  // one-byte instruction frame
  task automatic op(input logic [7:0] c);
    i_eewr_spi_master.start();
    sb(c);
    i_eewr_spi_master.stop();
  endtask : op

  // waits out any write cycle; accepted writes stand exactly WCYC cycles
  task automatic judge(input bit ok);
    for (int i = 0; i < WCYC + 20 && busy !== 1'b0; i++) @(negedge core_clk);
    @(negedge core_clk);
    if (ok) begin
      chk(busy_len, WCYC);
      chk(latch, 0);
    end else begin
      chk(busy_len, 0);
    end
  endtask : judge

  task automatic wr(input logic [15:0] a, input int n, input logic [7:0] base, input bit ok);
    busy_len = 0;
    frame(eewr_pkg::CMD_WRITE, a, n, base);
    i_eewr_spi_master.stop();
    if (ok) begin
      for (int k = 0; k < n; k++) exp_mem[{a[10:5], a[4:0] + 5'(k)}] = base + 8'(k);
    end
    judge(ok);
  endtask : wr

  task automatic set_prot(input logic hi, input logic lo, input logic lk);
    @(posedge core_clk);
    stat_bp_hi <= hi;
    stat_bp_lo <= lo;
    stat_lock <= lk;
    stat_load <= 1'b1;
    @(posedge core_clk);
    stat_load <= 1'b0;
    repeat (3) @(negedge core_clk);
    chk({bp_hi, bp_lo, lock}, {hi, lo, lk});
  endtask : set_prot

  task automatic t_delivery();
    chk({busy, latch, bp_hi, bp_lo, lock, miso_oe}, 0);
    rd(16'h07fe, 4);
  endtask : t_delivery

  task automatic t_page();
    op(eewr_pkg::WRITE_ENABLE_CMD);
    chk(latch, 1);
    wr(16'hf83c, 6, 8'h10, 1'b1);
    rd(16'h0020, 32);
    op(eewr_pkg::WRITE_ENABLE_CMD);
    wr(16'h07ff, 1, 8'ha5, 1'b1);
    op(eewr_pkg::WRITE_ENABLE_CMD);
    wr(16'h0000, 2, 8'h5a, 1'b1);
    rd(16'h07ff, 3);
  endtask : t_page

  task automatic t_reject();
    wr(16'h0100, 2, 8'h77, 1'b0);
    op(eewr_pkg::WRITE_ENABLE_CMD);
    frame(eewr_pkg::CMD_WRITE, 16'h0100, 0, 8'h00);
    i_eewr_spi_master.xbyte(8'h77, 5, q);
    i_eewr_spi_master.stop();
    judge(1'b0);
    wr(16'h0100, 0, 8'h00, 1'b0);
    chk(latch, 1);
    op(eewr_pkg::CMD_WRDI);
    chk(latch, 0);
    wr(16'h0100, 1, 8'h55, 1'b0);
    op(eewr_pkg::WRITE_ENABLE_CMD);
    set_prot(1'b1, 1'b1, 1'b1);
    wr(16'h0100, 1, 8'h66, 1'b0);
    set_prot(1'b0, 1'b1, 1'b0);
    wr(16'h0640, 1, 8'h66, 1'b0);
    wr(16'h0040, 1, 8'h3c, 1'b1);
    set_prot(1'b0, 1'b0, 1'b0);
    rd(16'h0040, 1);
    rd(16'h0100, 1);
    rd(16'h0640, 1);
  endtask : t_reject

  task automatic t_busy();
    op(eewr_pkg::WRITE_ENABLE_CMD);
    busy_len = 0;
    frame(eewr_pkg::CMD_WRITE, 16'h0080, 1, 8'h99);
    i_eewr_spi_master.stop();
    exp_mem[11'h080] = 8'h99;
    frame(eewr_pkg::CMD_READ, 16'h0080, 2, 8'h00);
    i_eewr_spi_master.stop();
    chk(i_eewr_spi_master.oe_seen, 0);
    frame(eewr_pkg::CMD_WRITE, 16'h00c0, 1, 8'h44);
    i_eewr_spi_master.stop();
    op(eewr_pkg::CMD_WRDI);
    chk(latch, 1);
    judge(1'b1);
    rd(16'h0080, 1);
    rd(16'h00c0, 1);
  endtask : t_busy

  initial begin
    #1000000;
    err_count++;
    complete_run();
  end

  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    stat_load = 1'b0;
    stat_bp_hi = 1'b0;
    stat_bp_lo = 1'b0;
    stat_lock = 1'b0;
    busy_len = 0;
    foreach (exp_mem[i]) exp_mem[i] = eewr_pkg::ERASED_BYTE;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    t_delivery();
    t_page();
    t_reject();
    t_busy();
    complete_run();
  end
endmodule : spi_eeprom_array_read_write_bench
